// ### hw/tmf_defs.svh
/*
 * Constants for the stream-three tributary multiframe marker link:
 * multiframe length and frame index encodings.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef TMF_DEFS_SVH
`define TMF_DEFS_SVH

`define TMF_FRAMES_PER_MF   4
`define TMF_FRAME_IDX_W     2
`define TMF_FIRST_FRAME     2'h0
`define TMF_LAST_FRAME      2'h3
`define TMF_DATA_W          8

`endif

// ### hw/tmf_pkg.sv
/*
 * Types shared by both ends of the multiframe marker link.
 * Assumes tmf_defs.svh is on the include path.
 */
`include "tmf_defs.svh"

package tmf_pkg;
    typedef logic [`TMF_FRAME_IDX_W-1:0] frame_idx_t;
    typedef logic [`TMF_DATA_W-1:0]      lane_byte_t;
    typedef enum logic [1:0] {
        pos_other,
        pos_h4,
        pos_j1_plus3
    } byte_pos_e;
endpackage

// ### hw/tmf_link_if.sv
/*
 * Interface joining the upstream framer (stream three) and the payload
 * processor's marker input. Assumes one shared clock, driven by the bench.
 */
`timescale 1ns/1ns

interface tmf_link_if (
    input wire logic clk_in
);
    import tmf_pkg::*;
    logic       incoming_multiframe_marker_3;
    lane_byte_t incoming_data_lane_three;
    logic       byte_is_h4;
    logic       byte_is_j1_plus3;
    logic       byte_valid;

    modport framer (
        output incoming_multiframe_marker_3,
        output incoming_data_lane_three,
        output byte_is_h4,
        output byte_is_j1_plus3,
        output byte_valid
    );
    modport processor (
        input incoming_multiframe_marker_3,
        input incoming_data_lane_three,
        input byte_is_h4,
        input byte_is_j1_plus3,
        input byte_valid
    );
endinterface

// ### hw/tmf_marker_in.sv
/*
 * Payload-processor end: tracks the tributary multiframe phase of stream
 * three from either the external marker or the H4 byte.
 * Assumes the framer flags H4 and third-byte-after-J1 positions on the
 * link and that all link signals are on clk_in.
 */
`timescale 1ns/1ns
`include "tmf_defs.svh"

module tmf_marker_in
    import tmf_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // configuration
    input  wire logic       marker_input_enable_in,
    input  wire logic       marker_h4_position_select_in,
    input  wire logic       incoming_rate_mode_n_in,
    // link
    tmf_link_if.processor   link,
    // multiframe status
    output logic            multiframe_start_out,
    output frame_idx_t      frame_index_out,
    output logic            aligned_out
);
    frame_idx_t frame_index;
    frame_idx_t next_frame_index;
    logic       start_q;
    logic       next_start_q;
    logic       aligned;
    logic       next_aligned;
    logic       h4_first;
    logic       marker_hit;
    logic       at_h4;
    logic       at_j1;

    assign at_h4 = link.byte_valid && link.byte_is_h4;
    assign at_j1 = link.byte_valid && link.byte_is_j1_plus3;

    always_comb begin
        next_frame_index = frame_index;
        next_start_q     = 1'b0;
        next_aligned     = aligned;
        h4_first         = 1'b0;
        marker_hit       = 1'b0;
        // frame count advances on every H4 byte unless a marker hit or the H4 phase load below overrides it
        if (at_h4) begin
            next_frame_index = frame_index + 2'h1;
        end
        if (marker_input_enable_in) begin
            // stm-4 mode: the pin is unused, so its level never reaches alignment
            if (incoming_rate_mode_n_in) begin
                if (marker_h4_position_select_in) begin
                    marker_hit = at_h4 && link.incoming_multiframe_marker_3;
                end else begin
                    marker_hit = at_j1 && link.incoming_multiframe_marker_3;
                end
            end
            if (marker_hit) begin
                next_aligned = 1'b1;
                if (marker_h4_position_select_in) begin
                    // h4 marker announces the next frame is the first
                    next_frame_index = `TMF_LAST_FRAME;
                end else begin
                    next_frame_index = `TMF_FIRST_FRAME;
                    next_start_q     = 1'b1;
                end
            end
        end else if (at_h4) begin
            // h4 low two bits give the phase; value 3 precedes the first frame
            h4_first     = (link.incoming_data_lane_three[1:0] == `TMF_LAST_FRAME);
            next_aligned = 1'b1;
            next_frame_index = link.incoming_data_lane_three[1:0];
        end
        // first frame begins at the h4 that follows the last-frame h4; in j1+3
        // marker mode the marker itself gives the start, so no second pulse
        if (at_h4 && (frame_index == `TMF_LAST_FRAME) && aligned && !marker_hit
            && !(marker_input_enable_in && !marker_h4_position_select_in)) begin
            next_start_q = 1'b1;
        end
        if (h4_first) begin
            next_start_q = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            frame_index <= `TMF_FIRST_FRAME;
            start_q     <= 1'b0;
            aligned     <= 1'b0;
        end else begin
            frame_index <= next_frame_index;
            start_q     <= next_start_q;
            aligned     <= next_aligned;
        end
    end

    assign multiframe_start_out = start_q;
    assign frame_index_out      = frame_index;
    assign aligned_out          = aligned;
endmodule

// ### hw/tmf_marker_drv.sv
/*
 * Framer end for stream three: walks a simple frame of BYTES_PER_FRAME
 * bytes, flags the H4 and third-byte-after-J1 positions, places the H4
 * phase on the lane and drives the multiframe marker.
 * Assumes the processor end shares clk_in.
 */
`timescale 1ns/1ns
`include "tmf_defs.svh"

module tmf_marker_drv
    import tmf_pkg::*;
#(
    parameter int BYTES_PER_FRAME = 16,
    parameter int J1_POS          = 2
)
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // user configuration
    input  wire logic       marker_h4_position_select_in,
    input  wire logic       incoming_rate_mode_n_in,
    input  wire logic       run_in,
    // link
    tmf_link_if.framer      link
);
    localparam int CW = $clog2(BYTES_PER_FRAME);
    // h4 sits ahead of j1+3 so the two marker slots fall on different bytes;
    // a simplified frame, not the real overhead spacing
    localparam int H4_POS = J1_POS + 1;

    if (BYTES_PER_FRAME < J1_POS + 4 || J1_POS < 0) begin
        $error("frame too short for J1 and H4 positions");
    end

    logic [CW-1:0] byte_cnt;
    logic [CW-1:0] next_byte_cnt;
    frame_idx_t    frame;
    frame_idx_t    next_frame;
    logic          marker;
    logic          next_marker;
    logic          is_h4;
    logic          is_j1;
    logic          next_is_h4;
    logic          next_is_j1;
    logic          valid;
    lane_byte_t    data;
    lane_byte_t    next_data;

    always_comb begin
        next_byte_cnt = byte_cnt;
        next_frame    = frame;
        next_is_h4    = 1'b0;
        next_is_j1    = 1'b0;
        next_data     = 8'h00;
        next_marker   = 1'b0;
        if (run_in) begin
            if (byte_cnt == CW'(BYTES_PER_FRAME - 1)) begin
                next_byte_cnt = '0;
                next_frame    = frame + 2'h1;
            end else begin
                next_byte_cnt = byte_cnt + 1'b1;
            end
            next_is_h4 = (next_byte_cnt == CW'(H4_POS));
            next_is_j1 = (next_byte_cnt == CW'(J1_POS + 3));
            if (next_is_h4) begin
                next_data = {6'h00, next_frame};
            end
            // held high across the whole marked frame, low on the other three
            if (incoming_rate_mode_n_in) begin
                if (marker_h4_position_select_in) begin
                    next_marker = (next_frame == `TMF_LAST_FRAME);
                end else begin
                    next_marker = (next_frame == `TMF_FIRST_FRAME);
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            byte_cnt <= '0;
            frame    <= `TMF_FIRST_FRAME;
            is_h4    <= 1'b0;
            is_j1    <= 1'b0;
            data     <= 8'h00;
            marker   <= 1'b0;
            valid    <= 1'b0;
        end else begin
            byte_cnt <= next_byte_cnt;
            frame    <= next_frame;
            is_h4    <= next_is_h4;
            is_j1    <= next_is_j1;
            data     <= next_data;
            marker   <= next_marker;
            valid    <= run_in;
        end
    end

    assign link.incoming_multiframe_marker_3 = marker;
    assign link.incoming_data_lane_three     = data;
    assign link.byte_is_h4                   = is_h4;
    assign link.byte_is_j1_plus3             = is_j1;
    assign link.byte_valid                   = valid;
endmodule

// ### verif/tmf_marker_in_assertions.sv
/*
 * Checker for the stream-three marker link and the processor's status.
 * Assumes the bench instantiates it beside tmf_link_if, one clock domain.
 */
`timescale 1ns/1ns

module tmf_marker_in_assertions
    import tmf_pkg::*;
(
    // clock and reset
    input wire logic       clk_in,
    input wire logic       reset_in,
    // configuration
    input wire logic       marker_input_enable_in,
    input wire logic       marker_h4_position_select_in,
    input wire logic       incoming_rate_mode_n_in,
    // link
    input wire logic       incoming_multiframe_marker_3,
    input wire lane_byte_t incoming_data_lane_three,
    input wire logic       byte_is_h4,
    input wire logic       byte_is_j1_plus3,
    input wire logic       byte_valid,
    // status
    input wire logic       multiframe_start_out,
    input wire frame_idx_t frame_index_out,
    input wire logic       aligned_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    wire mk  = byte_valid && incoming_rate_mode_n_in && marker_input_enable_in
               && incoming_multiframe_marker_3;
    wire sel = marker_h4_position_select_in;

    chk_j1_marker_start: assert property (
        mk && !sel && byte_is_j1_plus3 |=> multiframe_start_out && aligned_out
        && frame_index_out == 2'h0) else $error("j1 marker missed");
    chk_h4_marker_index: assert property (
        mk && sel && byte_is_h4 |=> aligned_out && frame_index_out == 2'h3)
        else $error("h4 marker missed");
    chk_h4_rollover: assert property (
        byte_valid && byte_is_h4 && sel && marker_input_enable_in && aligned_out
        && !incoming_multiframe_marker_3 && frame_index_out == 2'h3
        |=> multiframe_start_out && frame_index_out == 2'h0) else $error("no rollover");
    chk_j1_no_h4_start: assert property (
        byte_valid && byte_is_h4 && !byte_is_j1_plus3 && !sel && marker_input_enable_in
        |=> !multiframe_start_out) else $error("start at h4 in j1 mode");
    chk_start_single: assert property (
        multiframe_start_out |=> !multiframe_start_out) else $error("long start pulse");
    chk_phase_load: assert property (
        byte_valid && byte_is_h4 && !marker_input_enable_in
        |=> frame_index_out == $past(incoming_data_lane_three[1:0]))
        else $error("h4 phase not loaded");
    chk_other_bytes: assert property (
        !(byte_valid && (byte_is_h4 || byte_is_j1_plus3)) |=> !multiframe_start_out
        && $stable(frame_index_out) && $stable(aligned_out)) else $error("moved off slot");
    chk_marker_source: assert property (
        $rose(aligned_out) && marker_input_enable_in |-> $past(mk))
        else $error("aligned without marker");
    chk_reset_clear: assert property (disable iff (1'b0)
        reset_in |=> !aligned_out && !multiframe_start_out && frame_index_out == 2'h0)
        else $error("reset left status");

    cover property (multiframe_start_out && !sel);
    cover property (multiframe_start_out && sel);
    cover property (byte_is_h4 && !marker_input_enable_in);
endmodule

// ### verif/tributary_multiframe_marker_in_bench.sv
/*
 * Bench: framer end feeds processor end over tmf_link_if.
 * Assumes the hw package, defines and interface are compiled first.
 */
`timescale 1ns/1ns

module tributary_multiframe_marker_in_bench;
    import tmf_pkg::*;
    localparam int BPF = 16;
    logic       clk_in   = 1'b0;
    logic       reset_in = 1'b1;
    logic       en       = 1'b0;
    logic       sel      = 1'b0;
    logic       mode     = 1'b1;
    logic       drv_mode = 1'b1;
    logic       run      = 1'b0;
    logic       start;
    frame_idx_t idx;
    logic       aligned;
    int         error_cnt  = 0;
    int         num_checks = 0;

    always #4 clk_in = ~clk_in;

    tmf_link_if link (.clk_in(clk_in));
    tmf_marker_drv #(.BYTES_PER_FRAME(BPF)) tmf_marker_drv_i (.clk_in(clk_in),
        .reset_in(reset_in), .marker_h4_position_select_in(sel),
        .incoming_rate_mode_n_in(drv_mode), .run_in(run), .link(link));
    tmf_marker_in tmf_marker_in_i (.clk_in(clk_in), .reset_in(reset_in),
        .marker_input_enable_in(en), .marker_h4_position_select_in(sel),
        .incoming_rate_mode_n_in(mode), .link(link), .multiframe_start_out(start),
        .frame_index_out(idx), .aligned_out(aligned));
    tmf_marker_in_assertions tmf_marker_in_assertions_i (.clk_in(clk_in),
        .reset_in(reset_in), .marker_input_enable_in(en),
        .marker_h4_position_select_in(sel), .incoming_rate_mode_n_in(mode),
        .incoming_multiframe_marker_3(link.incoming_multiframe_marker_3),
        .incoming_data_lane_three(link.incoming_data_lane_three),
        .byte_is_h4(link.byte_is_h4), .byte_is_j1_plus3(link.byte_is_j1_plus3),
        .byte_valid(link.byte_valid), .multiframe_start_out(start),
        .frame_index_out(idx), .aligned_out(aligned));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // config only changes under reset, so neither end sees a mid-frame switch
    // dm sets the framer's own mode, so a live marker can meet an stm-4 processor
    task automatic restart(input logic e, input logic s, input logic m, input logic dm);
        @(posedge clk_in);
        reset_in <= 1'b1;
        run      <= 1'b0;
        en       <= e;
        sel      <= s;
        mode     <= m;
        drv_mode <= dm;
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        run      <= 1'b1;
    endtask

    // sampled at falling edges so registered outputs have settled
    task automatic wait_start(output int n, output int mk, output int h4);
        n  = 0;
        mk = 0;
        h4 = 0;
        do begin
            @(negedge clk_in);
            n++;
            mk += link.incoming_multiframe_marker_3;
            h4 += link.byte_valid && link.byte_is_h4;
        end while (start !== 1'b1 && n < 300);
    endtask

    task automatic t_marker(input logic s);
        int n, mk, h4;
        restart(1'b1, s, 1'b1, 1'b1);
        wait_start(n, mk, h4);
        check(idx, 2'h0);
        check(aligned, 1'b1);
        wait_start(n, mk, h4);
        check(n, 4 * BPF);
        check(mk <= BPF, 1'b1);
        check(h4, 4);
    endtask

    task automatic t_phase();
        frame_idx_t ph;
        restart(1'b0, 1'b0, 1'b1, 1'b1);
        repeat (4) begin
            @(negedge clk_in);
            for (int i = 0; i < 40 && !(link.byte_valid && link.byte_is_h4); i++)
                @(negedge clk_in);
            ph = link.incoming_data_lane_three[1:0];
            @(negedge clk_in);
            check(idx, ph);
        end
    endtask

    task automatic t_stm4();
        int n, mk, h4;
        restart(1'b1, 1'b0, 1'b0, 1'b0);
        wait_start(n, mk, h4);
        check(mk, 0);
        check(aligned, 1'b0);
        restart(1'b1, 1'b0, 1'b0, 1'b1);
        wait_start(n, mk, h4);
        check(n, 300);
        check(aligned, 1'b0);
        check(mk > 0, 1'b1);
    endtask

    initial begin
        t_marker(1'b0);
        t_marker(1'b1);
        t_phase();
        t_stm4();
        close_out();
    end

    initial begin
        #20000;
        error_cnt++;
        close_out();
    end
endmodule
